// ==== sasq_fifo.sv ====
`timescale 1ns/1ns
`default_nettype none
// Synchronous FIFO with honest full and empty flags.
module sasq_fifo #(
  parameter int W = 4,
  parameter int D = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Fill and drain sides.
  sasq_stream_if.sink s_in,
  sasq_stream_if.source s_out
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sasq_fifo_state_t;
  sasq_fifo_state_t s_r;
  sasq_fifo_state_t s_nxt;
  logic push;
  logic pop;

  // Handshakes follow the fill level.
  assign s_in.ready = (s_r.cnt != (AW+1)'(D));
  assign s_out.valid = (s_r.cnt != '0);
  assign s_out.data = s_r.mem[s_r.rp];
  assign push = s_in.valid & s_in.ready;
  assign pop = s_out.valid & s_out.ready;

  // Pointer and level update.
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = s_in.data;
      s_nxt.wp = (s_r.wp == AW'(D - 1)) ? '0 : AW'(s_r.wp + 1'b1);
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == AW'(D - 1)) ? '0 : AW'(s_r.rp + 1'b1);
    end
    s_nxt.cnt = (AW+1)'(s_r.cnt + push - pop);
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== sasq_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Host serial port model: drives shift clock, select and address, gathers the result.
module sasq_host_model (
  // System clock.
  input wire logic i_mclk,
  // Serial link to the converter.
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout
);
  logic half_clk;

  // The shift clock rests low and the address line toggles between frames.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end

  // Link timing base of 40 ns, free running with a phase of its own.
  initial begin
    half_clk = 1'b0;
    #13;
    forever #20 half_clk = ~half_clk;
  end

  // ----------------------------------------------------------------
  // One transfer of n shift clocks.
  // ----------------------------------------------------------------
  // The reply is read just before each rise; the 80 ns shift period keeps
  // the eleventh rise well ahead of the end of a conversion.
  task automatic xfer(input logic [3:0] a, input int n, output logic [15:0] rd);
    logic [3:0] sh;
    sh = a;
    rd = 16'h0000;
    @(posedge i_mclk);
    @(posedge half_clk);
    o_cs_n <= 1'b0;
    o_din <= sh[3];
    @(posedge half_clk);
    for (int k = 0; k < n; k++) begin
      rd = {rd[14:0], i_dout};
      o_sclk <= 1'b1;
      @(posedge half_clk);
      sh = {sh[2:0], ~sh[0]};
      o_sclk <= 1'b0;
      o_din <= sh[3];
      @(posedge half_clk);
    end
    o_cs_n <= 1'b1;
    o_din <= ~sh[3];
  endtask
endmodule
`default_nettype wire

// ==== sasq_pkg.sv ====
package sasq_pkg;
  // ----------------------------------------------------------------
  // Widths and codes.
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int RES_W = 10;
  localparam int CHAN_N = 11;
  localparam int TEST_N = 3;
  localparam logic [3:0] SEL_CHAN_LAST = 4'hA;
  localparam logic [3:0] SEL_TEST_MID = 4'hB;
  localparam logic [3:0] SEL_TEST_LOW = 4'hC;
  localparam logic [3:0] SEL_TEST_HIGH = 4'hD;
  localparam int TST_MID = 0;
  localparam int TST_LOW = 1;
  localparam int TST_HIGH = 2;
  localparam logic [9:0] RES_RESET = 10'h000;
  localparam logic EOC_RESET = 1'b1;
  // ----------------------------------------------------------------
  // Sequence counts and timing.
  // ----------------------------------------------------------------
  localparam int CONV_STEPS = 44;
  localparam int ADDR_RISES = 4;
  localparam int HOLD_FALL = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int MCLK_NS = 20;
  localparam int BBM_NS = 40;
  localparam int BBM_CYC = ((BBM_NS + MCLK_NS - 1) / MCLK_NS < 1) ? 1 :
                           (BBM_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int INT_TICK_NS = 1000;
  localparam int INT_TICK_CYC = (INT_TICK_NS / MCLK_NS < 1) ? 1 : INT_TICK_NS / MCLK_NS;
  // ----------------------------------------------------------------
  // Sequencer states.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_OPEN = 4'b0010,
    SEQ_SAMPLE = 4'b0100,
    SEQ_CONV = 4'b1000
  } sasq_seq_t;
endpackage

// ==== sasq_sar.sv ====
`timescale 1ns/1ns
`default_nettype none
// Successive approximation register stepped by conversion ticks.
module sasq_sar #(
  parameter int RES_W = 10,
  parameter int STEPS = 44
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Control.
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic i_cmp_above,
  // Result.
  output logic [RES_W-1:0] o_trial,
  output logic o_busy,
  output logic o_done
);
  typedef struct packed {
    logic [RES_W-1:0] trial;
    logic [3:0] bitpos;
    logic [5:0] cnt;
    logic busy;
    logic done;
  } sasq_sar_state_t;
  sasq_sar_state_t s_r;
  sasq_sar_state_t s_nxt;

  // The first tick only lets the comparator settle on the opening trial; the
  // next ten decide one bit each, MSB first, and the remaining steps pad time.
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (i_start) begin
      s_nxt.trial = RES_W'(1) << (RES_W - 1);
      s_nxt.bitpos = 4'(RES_W - 1);
      s_nxt.cnt = '0;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy && i_tick) begin
      if (s_r.cnt != 6'h00 && s_r.cnt <= 6'(RES_W)) begin
        // A comparator held high or low walks to all ones or to zero.
        if (!i_cmp_above) begin
          s_nxt.trial[s_r.bitpos] = 1'b0;
        end
        if (s_r.bitpos != 4'h0) begin
          s_nxt.trial[s_r.bitpos - 4'h1] = 1'b1;
          s_nxt.bitpos = s_r.bitpos - 4'h1;
        end
      end
      s_nxt.cnt = s_r.cnt + 6'h01;
      if (s_r.cnt == 6'(STEPS - 1)) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_trial = s_r.trial;
  assign o_busy = s_r.busy;
  assign o_done = s_r.done;
endmodule
`default_nettype wire

// ==== sasq_stream_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Valid and ready word stream between the block's own modules.
interface sasq_stream_if #(parameter int W = 4);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== sasq_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Serial converter control: shift port, channel select, sample and SAR sequence.
module sasq_top #(
  parameter bit P_EXT_CONV_CLK = 1'b1,
  parameter int P_FIFO_DEPTH = sasq_pkg::FIFO_DEPTH
) (
  // System clock and reset.
  input wire logic i_mclk,
  input wire logic i_resetn,
  // Serial link from the host.
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe,
  // Conversion clock and end of conversion.
  input wire logic i_conversion_clock_in,
  output logic o_eoc,
  // Analog front end.
  output logic [sasq_pkg::CHAN_N-1:0] o_analog_channel_close,
  output logic [sasq_pkg::TEST_N-1:0] o_test_close,
  output logic o_sample,
  output logic [sasq_pkg::RES_W-1:0] o_sample_capacitor_array,
  input wire logic i_cmp_above
);
  // ----------------------------------------------------------------
  // Link domain on the shift clock.
  // ----------------------------------------------------------------
  logic link_rst;
  logic [2:0] rise_cnt_r;
  logic [2:0] shift_r;
  logic [3:0] addr_r;
  logic addr_tgl_r;
  logic [3:0] fall_cnt_r;
  logic hold_tgl_r;
  logic [3:0] dout_idx;

  // Chip select high or system reset clears the transfer counters.
  assign link_rst = i_cs_n | ~i_resetn;

  // Address bits enter MSB first on the first four rises only.
  always_ff @(posedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      rise_cnt_r <= 3'h0;
      shift_r <= 3'h0;
    end else if (rise_cnt_r < 3'(sasq_pkg::ADDR_RISES)) begin
      rise_cnt_r <= rise_cnt_r + 3'h1;
      shift_r <= {shift_r[1:0], i_din};
    end
  end

  // The full address is kept until the next transfer's fourth rise.
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_r <= 4'h0;
      addr_tgl_r <= 1'b0;
    end else if (!i_cs_n && rise_cnt_r == 3'(sasq_pkg::ADDR_RISES - 1)) begin
      addr_r <= {shift_r, i_din};
      addr_tgl_r <= ~addr_tgl_r;
    end
  end

  // Falling edges step the result out and stop at the hold edge.
  always_ff @(negedge i_sclk or posedge link_rst) begin
    if (link_rst) begin
      fall_cnt_r <= 4'h0;
    end else if (fall_cnt_r < 4'(sasq_pkg::HOLD_FALL)) begin
      fall_cnt_r <= fall_cnt_r + 4'h1;
    end
  end

  // The tenth fall hands the sequence over to the conversion side.
  always_ff @(negedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_tgl_r <= 1'b0;
    end else if (!i_cs_n && fall_cnt_r == 4'(sasq_pkg::HOLD_FALL - 1)) begin
      hold_tgl_r <= ~hold_tgl_r;
    end
  end

  // ----------------------------------------------------------------
  // System domain state.
  // ----------------------------------------------------------------
  typedef struct packed {
    sasq_pkg::sasq_seq_t st;
    logic [3:0] sel;
    logic [sasq_pkg::CHAN_N-1:0] mux;
    logic [sasq_pkg::TEST_N-1:0] tst;
    logic smp;
    logic eoc;
    logic [sasq_pkg::RES_W-1:0] res;
    logic hold_pend;
    logic [2:0] bbm;
    logic [2:0] a_sync;
    logic [2:0] h_sync;
    logic [2:0] c_sync;
    logic [1:0] cmp_sync;
    logic push_v;
    logic [3:0] push_d;
    logic [5:0] div;
    logic start;
  } sasq_top_state_t;
  sasq_top_state_t s_r;
  sasq_top_state_t s_nxt;
  logic a_evt;
  logic h_evt;
  logic conv_tick;
  logic sar_busy;
  logic sar_done;
  logic [sasq_pkg::RES_W-1:0] sar_trial;

  sasq_stream_if #(.W(sasq_pkg::ADDR_W)) push_if();
  sasq_stream_if #(.W(sasq_pkg::ADDR_W)) pop_if();

  // Result word is quiet during a transfer, so the link reads it directly.
  assign dout_idx = 4'(sasq_pkg::RES_W - 1) - fall_cnt_r;
  assign o_dout = (fall_cnt_r < 4'(sasq_pkg::HOLD_FALL)) ?
                  s_r.res[dout_idx] : 1'b0;
  assign o_dout_oe = ~i_cs_n;

  // ----------------------------------------------------------------
  // Select decoding.
  // ----------------------------------------------------------------
  // One external switch per code up to the last channel.
  function automatic logic [sasq_pkg::CHAN_N-1:0] dec_chan(input logic [3:0] sel);
    logic [sasq_pkg::CHAN_N-1:0] m;
    m = '0;
    if (sel <= sasq_pkg::SEL_CHAN_LAST) begin
      m[sel] = 1'b1;
    end
    return m;
  endfunction

  // Reference test sources; codes above them close nothing.
  function automatic logic [sasq_pkg::TEST_N-1:0] dec_test(input logic [3:0] sel);
    logic [sasq_pkg::TEST_N-1:0] t;
    t = '0;
    if (sel == sasq_pkg::SEL_TEST_MID) begin
      t[sasq_pkg::TST_MID] = 1'b1;
    end else if (sel == sasq_pkg::SEL_TEST_LOW) begin
      t[sasq_pkg::TST_LOW] = 1'b1;
    end else if (sel == sasq_pkg::SEL_TEST_HIGH) begin
      t[sasq_pkg::TST_HIGH] = 1'b1;
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // Crossings and conversion tick.
  // ----------------------------------------------------------------
  // Edge detection reads only the second and third synchroniser stages.
  assign a_evt = s_r.a_sync[1] ^ s_r.a_sync[2];
  assign h_evt = s_r.h_sync[1] ^ s_r.h_sync[2];
  assign conv_tick = P_EXT_CONV_CLK ? (s_r.c_sync[1] & ~s_r.c_sync[2]) :
                     (s_r.div == 6'(sasq_pkg::INT_TICK_CYC - 1));

  // Address queue between the link and the sequencer.
  assign push_if.valid = s_r.push_v;
  assign push_if.data = s_r.push_d;
  assign pop_if.ready = (s_r.st == sasq_pkg::SEQ_IDLE);

  sasq_fifo #(
    .W(sasq_pkg::ADDR_W),
    .D(P_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_mclk),
    .i_rstn(i_resetn),
    .s_in(push_if),
    .s_out(pop_if)
  );

  sasq_sar #(
    .RES_W(sasq_pkg::RES_W),
    .STEPS(sasq_pkg::CONV_STEPS)
  ) u_sar (
    .i_clk(i_mclk),
    .i_rstn(i_resetn),
    .i_start(s_r.start),
    .i_tick(conv_tick),
    .i_cmp_above(s_r.cmp_sync[1]),
    .o_trial(sar_trial),
    .o_busy(sar_busy),
    .o_done(sar_done)
  );

  // ----------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------
  // Next state: queue the address, open, sample, hold and convert.
  always_comb begin
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.a_sync = {s_r.a_sync[1:0], addr_tgl_r};
    s_nxt.h_sync = {s_r.h_sync[1:0], hold_tgl_r};
    s_nxt.c_sync = {s_r.c_sync[1:0], i_conversion_clock_in};
    s_nxt.cmp_sync = {s_r.cmp_sync[0], i_cmp_above};
    s_nxt.div = (s_r.div == 6'(sasq_pkg::INT_TICK_CYC - 1)) ? 6'h00 : s_r.div + 6'h01;
    // A full queue holds the word here until room appears.
    if (s_r.push_v && push_if.ready) begin
      s_nxt.push_v = 1'b0;
    end
    if (a_evt) begin
      s_nxt.push_v = 1'b1;
      s_nxt.push_d = addr_r;
    end
    case (s_r.st)
      sasq_pkg::SEQ_IDLE: begin
        if (pop_if.valid) begin
          s_nxt.sel = pop_if.data;
          s_nxt.mux = '0;
          s_nxt.tst = '0;
          s_nxt.bbm = 3'(sasq_pkg::BBM_CYC - 1);
          s_nxt.st = sasq_pkg::SEQ_OPEN;
        end
      end
      sasq_pkg::SEQ_OPEN: begin
        if (s_r.bbm == 3'h0) begin
          s_nxt.mux = dec_chan(s_r.sel);
          s_nxt.tst = dec_test(s_r.sel);
          s_nxt.smp = 1'b1;
          s_nxt.st = sasq_pkg::SEQ_SAMPLE;
        end else begin
          s_nxt.bbm = s_r.bbm - 3'h1;
        end
      end
      sasq_pkg::SEQ_SAMPLE: begin
        if (s_r.hold_pend) begin
          s_nxt.hold_pend = 1'b0;
          s_nxt.smp = 1'b0;
          s_nxt.eoc = 1'b0;
          s_nxt.start = 1'b1;
          s_nxt.st = sasq_pkg::SEQ_CONV;
        end
      end
      sasq_pkg::SEQ_CONV: begin
        if (sar_done) begin
          s_nxt.res = sar_trial;
          s_nxt.eoc = 1'b1;
          s_nxt.st = sasq_pkg::SEQ_IDLE;
        end
      end
      default: begin
        s_nxt.st = sasq_pkg::SEQ_IDLE;
      end
    endcase
    // A new hold edge wins over the clear of the one just used.
    if (h_evt) begin
      s_nxt.hold_pend = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_r <= '0;
      s_r.st <= sasq_pkg::SEQ_IDLE;
      s_r.eoc <= sasq_pkg::EOC_RESET;
      s_r.res <= sasq_pkg::RES_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register, the capacitor array from the SAR's register.
  assign o_analog_channel_close = s_r.mux;
  assign o_test_close = s_r.tst;
  assign o_sample = s_r.smp;
  assign o_eoc = s_r.eoc;
  assign o_sample_capacitor_array = sar_trial;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  logic [5:0] tick_seen;
  logic all_hi;
  logic all_lo;

  // Count ticks and comparator extremes over one conversion.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_seen <= 6'h00;
      all_hi <= 1'b0;
      all_lo <= 1'b0;
    end else if (s_r.start) begin
      tick_seen <= 6'h00;
      all_hi <= 1'b1;
      all_lo <= 1'b1;
    end else if (sar_busy && conv_tick) begin
      tick_seen <= tick_seen + 6'h01;
      all_hi <= all_hi & s_r.cmp_sync[1];
      all_lo <= all_lo & ~s_r.cmp_sync[1];
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence seq_hold_taken;
    s_r.st == sasq_pkg::SEQ_SAMPLE && s_r.hold_pend;
  endsequence

  sequence seq_conv_entered;
    !o_eoc && !o_sample && s_r.st == sasq_pkg::SEQ_CONV;
  endsequence

  property p_hold_to_conv;
    seq_hold_taken |=> seq_conv_entered;
  endproperty

  a_hold_eoc_low: assert property (p_hold_to_conv)
    else $error("hold did not start conversion with eoc low");

  a_sample_window: assert property (o_sample |-> s_r.st == sasq_pkg::SEQ_SAMPLE)
    else $error("sampling outside the sample phase");

  a_conv_length: assert property (sar_done |-> tick_seen == 6'(sasq_pkg::CONV_STEPS))
    else $error("conversion length is not 44 ticks");

  a_result_ready: assert property (sar_done |=> o_eoc && s_r.res == $past(sar_trial))
    else $error("result not stored with eoc high");

  a_saturate_ends: assert property (sar_done && (all_hi || all_lo) |->
    sar_trial == (all_hi ? 10'h3FF : 10'h000))
    else $error("saturated comparator did not give an end code");

  a_break_make: assert property ((o_analog_channel_close != '0 &&
    $past(o_analog_channel_close) != '0) |->
    o_analog_channel_close == $past(o_analog_channel_close))
    else $error("switch moved without opening first");

  a_chan_decode: assert property ((s_r.st == sasq_pkg::SEQ_SAMPLE &&
    s_r.sel <= sasq_pkg::SEL_CHAN_LAST) |->
    o_analog_channel_close == (11'h001 << s_r.sel) && o_test_close == 3'h0)
    else $error("external channel decode wrong");

  a_test_decode: assert property ((s_r.st == sasq_pkg::SEQ_SAMPLE &&
    s_r.sel > sasq_pkg::SEL_CHAN_LAST) |-> o_analog_channel_close == '0 &&
    o_test_close == ((s_r.sel > sasq_pkg::SEL_TEST_HIGH) ? 3'h0 :
    (3'h1 << (s_r.sel - sasq_pkg::SEL_TEST_MID))))
    else $error("test source decode wrong");

  a_addr_follow: assert property ((pop_if.valid && pop_if.ready) |=>
    s_r.sel == $past(pop_if.data) ##1 s_r.st == sasq_pkg::SEQ_OPEN)
    else $error("queued address not taken as next select");

  a_dout_zero: assert property (@(negedge i_sclk) disable iff (link_rst)
    fall_cnt_r == 4'(sasq_pkg::HOLD_FALL) |-> !o_dout)
    else $error("dout not low after the tenth fall");
endmodule
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the converter sequencer.
module tb_top;
  logic i_mclk, i_resetn, i_conv, i_cmp_above, sclk, cs_n, din;
  logic o_dout, o_dout_oe, o_eoc, o_sample;
  logic [10:0] o_ch;
  logic [2:0] o_tst;
  logic [9:0] o_trial, prev;
  logic [13:0] sw_at, prev_sw;
  logic prev_ok;
  int fails = 0, n_compared = 0, cycles = 0, seed = 86, held = 0, low_n = 0, last_len = 0;
  int val[14];

  sasq_top sasq_top_i (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .o_dout(o_dout), .o_dout_oe(o_dout_oe), .i_conversion_clock_in(i_conv),
    .o_eoc(o_eoc), .o_analog_channel_close(o_ch), .o_test_close(o_tst),
    .o_sample(o_sample), .o_sample_capacitor_array(o_trial), .i_cmp_above(i_cmp_above)
  );
  sasq_host_model sasq_host_model_i (
    .i_mclk(i_mclk), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(o_dout)
  );

  // ----------------------------------------------------------------
  // Clocks.
  // ----------------------------------------------------------------
  // The conversion clock runs free with its own phase.
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  initial begin
    i_conv = 1'b0;
    #7;
    forever #40 i_conv = ~i_conv;
  end

  // ----------------------------------------------------------------
  // Analog front end, monitors and checks.
  // ----------------------------------------------------------------
  function automatic int in_val(input logic [13:0] sw);
    for (int i = 0; i < 14; i++) if (sw[i]) return val[i];
    return 0;
  endfunction
  // Sample and hold plus comparator; the held level may lie beyond either reference.
  always @(posedge i_mclk) begin
    if (o_sample === 1'b1) begin
      held <= in_val({o_tst, o_ch});
      sw_at <= {o_tst, o_ch};
    end
    i_cmp_above <= (held >= int'(o_trial));
    if (o_eoc === 1'b0) low_n <= low_n + 1;
    else if (low_n > 0) begin
      last_len <= low_n;
      low_n <= 0;
    end
  end
  task automatic mism(input string m);
    fails++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  // Two switches are never closed together across a change of channel.
  always @(negedge i_mclk) begin
    cycles++;
    if (prev_sw !== 14'h0000 && {o_tst, o_ch} !== 14'h0000 && {o_tst, o_ch} !== prev_sw)
      mism("switches overlap");
    prev_sw = {o_tst, o_ch};
    chk_b(o_dout_oe, ~cs_n, "output enable");
    if (cycles > 60000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) mism(m);
  endtask
  task automatic chk_b(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) mism(m);
  endtask
  // Expected result of a code, clipped at both references.
  function automatic logic [9:0] exp_res(input logic [3:0] c);
    int v;
    if (c == 4'hB) return 10'h200;
    if (c == 4'hC) return 10'h000;
    if (c == 4'hD) return 10'h3FF;
    if (c > 4'hD) return 10'h000;
    v = val[c];
    return (v > 1023) ? 10'h3FF : (v < 0) ? 10'h000 : v[9:0];
  endfunction
  function automatic logic [13:0] exp_sw(input logic [3:0] c);
    return (c > 4'hD) ? 14'h0000 : 14'h0001 << c;
  endfunction

  // ----------------------------------------------------------------
  // One transfer followed by the wait for its conversion.
  // ----------------------------------------------------------------
  task automatic run_one(input logic [3:0] c, input int n);
    logic [15:0] rd;
    int t;
    sw_at = 14'h0000;
    last_len = 0;
    sasq_host_model_i.xfer(c, n, rd);
    if (prev_ok) chk_w(rd >> (n - 10), {6'h00, prev}, "previous result");
    if (n == 16) chk_w({10'h000, rd[5:0]}, 16'h0000, "trailing bits");
    t = 0;
    while (last_len == 0 && t < 400) begin
      @(posedge i_mclk);
      t++;
    end
    chk_b(last_len >= 170 && last_len <= 184, 1'b1, "conversion length");
    chk_b(o_sample, 1'b0, "sample after hold");
    chk_w({2'b00, sw_at}, {2'b00, exp_sw(c)}, "selected");
    prev = exp_res(c);
    prev_ok = (c <= 4'hD);
  endtask

  // Reset, every code in turn, then random codes and lengths.
  initial begin
    i_resetn = 1'b0;
    i_cmp_above = 1'b0;
    prev = 10'h000;
    prev_ok = 1'b1;
    prev_sw = 14'h0000;
    sw_at = 14'h0000;
    for (int i = 0; i < 11; i++) val[i] = $random(seed) % 1200;
    val[0] = 1500;
    val[1] = -40;
    val[11] = 512;
    val[12] = 0;
    val[13] = 1023;
    repeat (20) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
    for (int c = 0; c < 16; c++) run_one(c[3:0], 10 + 6 * (c % 2));
    repeat (16) run_one(4'($unsigned($random(seed)) % 14), ($random(seed) & 1) ? 16 : 10);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Verdict.
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
endmodule
`default_nettype wire
